// ==== rtl/vds_params.svh ====
`ifndef VDS_PARAMS_SVH
`define VDS_PARAMS_SVH

// Register offsets
`define VDS_OFS_SETUP 8'h40
`define VDS_OFS_LSS_FIRST 8'h41
`define VDS_OFS_LSS_LAST 8'h57
`define VDS_OFS_HORIZ_OFFSET_LOW_LO 8'h59
`define VDS_OFS_VERT_OFFSET_LOW_LO 8'h5a
`define VDS_OFS_OFF_HI 8'h5b
`define VDS_OFS_FC_PROG 8'h5c
`define VDS_OFS_STATUS 8'h5d

// Field positions
`define VDS_SETUP_ERR 1:0
`define VDS_SETUP_OPT_HAM 6
`define VDS_HI_HORIZ_OFFSET_LOW 2:0
`define VDS_HI_VERT_OFFSET_LOW 4
`define VDS_HI_FIELD_OFFSET_FLAG 7
`define VDS_LSS_FIELD0 7:4
`define VDS_LSS_FIELD1 3:0

// Reset values
`define VDS_RST_SETUP 8'h00
`define VDS_RST_LSS 8'hff
`define VDS_RST_OFF 8'h00
`define VDS_RST_FC 8'h27

// Bit rates in bit/s and the phase increments they give at the system clock
`define VDS_CLK_HZ 50000000
`define VDS_INC(r) (24'((64'(r) << 24) / 64'(`VDS_CLK_HZ)))
`define VDS_I_6M94 `VDS_INC(6937500)
`define VDS_I_0M500 `VDS_INC(500000)
`define VDS_I_0M503 `VDS_INC(503000)
`define VDS_I_5M `VDS_INC(5000000)
`define VDS_I_5M73 `VDS_INC(5727200)
`define VDS_I_1M81 `VDS_INC(1812500)
`define VDS_I_1M79 `VDS_INC(1789800)
`define VDS_PHASE_HALF 24'h800000

// Framing words, oldest bit in the least significant position
`define VDS_FC_TXT 24'h000027
`define VDS_FC_CC 24'h000004
`define VDS_FC_PDC 24'h009951
`define VDS_FC_WSS 24'h1e3c1f

// Framing search windows in bits after lock
`define VDS_W_TXT 8'd24
`define VDS_W_CC 8'd24
`define VDS_W_WIDE 8'd32
`define VDS_W_OPEN 8'hff

// Lock, line and buffer counts
`define VDS_LOCK_EDGES 4'd6
`define VDS_RUNIN_MAX 6'd40
`define VDS_LINES 23
`define VDS_LINE_FIRST 5'd2
`define VDS_SECT_BYTES 56
`define VDS_HAM_BYTES 6'd2

`endif

// ==== rtl/vds_pkg.sv ====
package vds_pkg;

	typedef logic [3:0] vds_code_t;

	typedef enum {S_IDLE, S_WAIT, S_RUNIN, S_FRAME, S_DATA} vds_state_t;

	typedef struct packed {
		logic [23:0] inc;
		logic [4:0] fc_len;
		logic [23:0] fc_word;
		logic [7:0] fc_win;
		logic ham;
		logic search;
		logic active;
	} vds_std_t;

endpackage : vds_pkg

// ==== rtl/vds_text_buffer.sv ====
`timescale 1ns/10ps
`include "vds_params.svh"

module vds_text_buffer #(
	parameter int SECT_BYTES = `VDS_SECT_BYTES,
	parameter int TAG_W = 9
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Fill side
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic wr_commit,
	input wire logic wr_abort,
	input wire logic [TAG_W-1:0] wr_tag,
	output logic wr_free,
	// Drain side
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rd_last,
	output logic [TAG_W-1:0] rd_tag,
	input wire logic rd_ready
);
	localparam int PW = $clog2(SECT_BYTES + 1);
	localparam int AW = $clog2(2 * SECT_BYTES);

	logic [7:0] mem [0:2*SECT_BYTES-1];
	logic [1:0] full_reg;
	logic [PW-1:0] cnt_reg [0:1];
	logic [TAG_W-1:0] tag_reg [0:1];
	logic wsec_reg;
	logic rsec_reg;
	logic [PW-1:0] wptr_reg;
	logic [PW-1:0] rptr_reg;
	logic load;
	logic release_sec;
	logic commit_ok;
	logic take;

	function automatic logic [AW-1:0] addr_of(input logic sec, input logic [PW-1:0] ptr);
		addr_of = sec ? AW'(SECT_BYTES) + AW'(ptr) : AW'(ptr);
	endfunction : addr_of

	assign wr_free = !full_reg[wsec_reg];
	// A byte written in the commit cycle still belongs to the line
	assign take = wr_en && wr_free && wptr_reg < PW'(SECT_BYTES);
	assign commit_ok = wr_commit && (wptr_reg != '0 || take) && wr_free;
	assign load = full_reg[rsec_reg] && (!rd_valid || rd_ready);
	assign release_sec = load && (rptr_reg == cnt_reg[rsec_reg] - PW'(1));

	// Fill pointer of the open section
	always_ff @(posedge clk_sys)
	begin
		if (srst || wr_commit || wr_abort)
			wptr_reg <= '0;
		else if (wr_en && wr_free && wptr_reg < PW'(SECT_BYTES))
			wptr_reg <= wptr_reg + PW'(1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (wr_en && wr_free && wptr_reg < PW'(SECT_BYTES))
			mem[addr_of(wsec_reg, wptr_reg)] <= wr_data;
	end

	// A line only becomes visible once whole
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wsec_reg <= 1'b0;
			cnt_reg[0] <= '0;
			cnt_reg[1] <= '0;
			tag_reg[0] <= '0;
			tag_reg[1] <= '0;
		end
		else if (commit_ok)
		begin
			cnt_reg[wsec_reg] <= wptr_reg + PW'(take);
			tag_reg[wsec_reg] <= wr_tag;
			wsec_reg <= ~wsec_reg;
		end
	end

	for (genvar i = 0; i < 2; i++)
	begin : g_sect
		always_ff @(posedge clk_sys)
		begin
			if (srst)
				full_reg[i] <= 1'b0;
			else if (commit_ok && wsec_reg == 1'(i))
				full_reg[i] <= 1'b1;
			else if (release_sec && rsec_reg == 1'(i))
				full_reg[i] <= 1'b0;
		end
	end

	// Drain stage, one byte per accepted beat
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			rd_last <= 1'b0;
			rd_tag <= '0;
			rptr_reg <= '0;
			rsec_reg <= 1'b0;
		end
		else if (load)
		begin
			rd_valid <= 1'b1;
			rd_data <= mem[addr_of(rsec_reg, rptr_reg)];
			rd_last <= release_sec;
			rd_tag <= tag_reg[rsec_reg];
			rptr_reg <= release_sec ? '0 : rptr_reg + PW'(1);
			rsec_reg <= release_sec ? ~rsec_reg : rsec_reg;
		end
		else if (rd_ready)
		begin
			rd_valid <= 1'b0;
			rd_last <= 1'b0;
		end
	end

endmodule : vds_text_buffer

// ==== rtl/vds_slicer.sv ====
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`include "vds_params.svh"
// Behaviour
// - Lock sampling phase to data clock during run-in before sampling bits
// - Sample bits at the line standard's rate, pack them into bytes
// - Store bytes in a buffer of two 56-byte sections
// - Lines 2 to 24 each select one of 16 standards by 4-bit code
// - Line 24 selection holds for the rest of the field
// - Horizontal and vertical offsets plus field offset bit are programmable
// - Offsets count from falling line and vertical reference edges
// - Code 0000: 6.9375 Mbit/s teletext, framing 27H, Hamming checked
// - Code 0001: 0.500 Mbit/s caption, start pattern 001 framing
// - Code 0101: 0.503 Mbit/s caption, start pattern 001 framing
// - Programme service framing 9951H, code 0011 framing 1E3C1FH, 5 Mbit/s
// - Codes 0110, 0111, 1111 skip framing; 1111 sends nothing
// - Code 1001 at 1.8125, code 1010 at 1.7898 Mbit/s, programmable framing
// - Code 1110 at 5 Mbit/s, programmable framing, open window
// - Whole line collected in one section before transfer is offered

module vds_slicer #(
	parameter int LINES = `VDS_LINES,
	parameter int SECT_BYTES = `VDS_SECT_BYTES
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Decoder video stream
	input wire logic [7:0] vid_sample,
	input wire logic line_reference,
	input wire logic vertical_reference,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sliced text stream
	output logic [7:0] txt_data,
	output logic txt_valid,
	output logic txt_last,
	output logic [4:0] txt_line,
	output vds_pkg::vds_code_t txt_std,
	input wire logic txt_ready
);
	import vds_pkg::*;

	logic [7:0] setup_reg;
	logic [7:0] lss_reg [0:LINES-1];
	logic [7:0] horiz_offset_low_lo_reg;
	logic [7:0] vert_offset_low_lo_reg;
	logic [7:0] off_hi_reg;
	logic [7:0] fc_prog_reg;
	logic lref_d_reg;
	logic vref_d_reg;
	logic lref_fall;
	logic vref_fall;
	logic [8:0] vcnt_reg;
	logic field_reg;
	logic [10:0] hcnt_reg;
	logic [10:0] horiz_trigger_offset;
	logic [8:0] vert_trigger_offset;
	logic field_sel;
	logic [8:0] vrel;
	logic [4:0] tline;
	logic [4:0] line_num;
	vds_code_t cur_code;
	vds_code_t std_reg;
	vds_std_t info;
	vds_std_t cur_info;
	vds_state_t state_reg;
	logic [7:0] min_reg;
	logic [7:0] max_reg;
	logic [8:0] lvl_sum;
	logic sbit;
	logic sbit_d_reg;
	logic sedge;
	logic [24:0] phase_sum;
	logic [23:0] phase_reg;
	logic tick;
	logic [3:0] edges_reg;
	logic [5:0] rbits_reg;
	logic [7:0] fbits_reg;
	logic [23:0] sh_reg;
	logic [23:0] sh_nx;
	logic fc_match;
	logic [7:0] byte_reg;
	logic [7:0] byte_nx;
	logic [2:0] bcnt_reg;
	logic [5:0] nbytes_reg;
	logic [1:0] errs_reg;
	logic ham_fail;
	logic [4:0] line_reg;
	logic last_ok_reg;
	logic wr_en_reg;
	logic wr_commit_reg;
	logic wr_abort_reg;
	logic wr_free;

	function automatic logic lss_hit(input logic [7:0] a);
		lss_hit = (a >= `VDS_OFS_LSS_FIRST) && (a <= `VDS_OFS_LSS_LAST);
	endfunction : lss_hit

	function automatic logic ham_bad(input logic [7:0] b);
		ham_bad = ~^b;
	endfunction : ham_bad

	function automatic vds_std_t std_info(input vds_code_t c, input logic [7:0] fc,
		input logic opt_ham);
		vds_std_t s;
		logic [23:0] pw;
		pw = {16'h0000, fc};
		s = '{`VDS_I_5M, 5'd8, pw, `VDS_W_WIDE, 1'b0, 1'b1, 1'b1};
		unique case (c)
			4'h0: s = '{`VDS_I_6M94, 5'd8, `VDS_FC_TXT, `VDS_W_TXT, 1'b1, 1'b1, 1'b1};
			4'h1: s = '{`VDS_I_0M500, 5'd3, `VDS_FC_CC, `VDS_W_CC, 1'b0, 1'b1, 1'b1};
			4'h2: s = '{`VDS_I_5M, 5'd16, `VDS_FC_PDC, `VDS_W_WIDE, 1'b0, 1'b1, 1'b1};
			4'h3: s = '{`VDS_I_5M, 5'd24, `VDS_FC_WSS, `VDS_W_WIDE, 1'b0, 1'b1, 1'b1};
			4'h4: s = '{`VDS_I_5M73, 5'd8, `VDS_FC_TXT, `VDS_W_TXT, 1'b1, 1'b1, 1'b1};
			4'h5: s = '{`VDS_I_0M503, 5'd3, `VDS_FC_CC, `VDS_W_CC, 1'b0, 1'b1, 1'b1};
			4'h6, 4'h7: s = '{`VDS_I_5M, 5'd8, pw, `VDS_W_OPEN, 1'b0, 1'b0, 1'b1};
			4'h8: s = '{`VDS_I_6M94, 5'd8, pw, `VDS_W_WIDE, opt_ham, 1'b1, 1'b1};
			4'h9: s = '{`VDS_I_1M81, 5'd8, pw, `VDS_W_WIDE, 1'b0, 1'b1, 1'b1};
			4'ha: s = '{`VDS_I_1M79, 5'd8, pw, `VDS_W_WIDE, 1'b0, 1'b1, 1'b1};
			4'hb: s = '{`VDS_I_5M, 5'd8, pw, `VDS_W_OPEN, 1'b0, 1'b1, 1'b1};
			4'hc: s = '{`VDS_I_5M73, 5'd8, pw, `VDS_W_WIDE, opt_ham, 1'b1, 1'b1};
			4'hd: s = '{`VDS_I_5M73, 5'd8, pw, `VDS_W_WIDE, 1'b0, 1'b1, 1'b1};
			4'he: s = '{`VDS_I_5M, 5'd8, pw, `VDS_W_OPEN, 1'b0, 1'b1, 1'b1};
			4'hf: s = '{`VDS_I_5M, 5'd8, pw, `VDS_W_OPEN, 1'b0, 1'b0, 1'b0};
		endcase
		return s;
	endfunction : std_info

	// Register writes
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			setup_reg <= `VDS_RST_SETUP;
			horiz_offset_low_lo_reg <= `VDS_RST_OFF;
			vert_offset_low_lo_reg <= `VDS_RST_OFF;
			off_hi_reg <= `VDS_RST_OFF;
			fc_prog_reg <= `VDS_RST_FC;
			for (int i = 0; i < LINES; i++)
				lss_reg[i] <= `VDS_RST_LSS;
		end
		else if (reg_wr)
		begin
			if (lss_hit(reg_addr))
				lss_reg[5'(reg_addr - `VDS_OFS_LSS_FIRST)] <= reg_wdata;
			case (reg_addr)
				`VDS_OFS_SETUP: setup_reg <= reg_wdata;
				`VDS_OFS_HORIZ_OFFSET_LOW_LO: horiz_offset_low_lo_reg <= reg_wdata;
				`VDS_OFS_VERT_OFFSET_LOW_LO: vert_offset_low_lo_reg <= reg_wdata;
				`VDS_OFS_OFF_HI: off_hi_reg <= reg_wdata;
				`VDS_OFS_FC_PROG: fc_prog_reg <= reg_wdata;
				default: setup_reg <= setup_reg;
			endcase
		end
	end

	// Register reads, data valid in the following cycle only
	always_ff @(posedge clk_sys)
	begin
		if (srst || !reg_rd)
			reg_rdata <= 8'h00;
		else if (lss_hit(reg_addr))
			reg_rdata <= lss_reg[5'(reg_addr - `VDS_OFS_LSS_FIRST)];
		else
		begin
			case (reg_addr)
				`VDS_OFS_SETUP: reg_rdata <= setup_reg;
				`VDS_OFS_HORIZ_OFFSET_LOW_LO: reg_rdata <= horiz_offset_low_lo_reg;
				`VDS_OFS_VERT_OFFSET_LOW_LO: reg_rdata <= vert_offset_low_lo_reg;
				`VDS_OFS_OFF_HI: reg_rdata <= off_hi_reg;
				`VDS_OFS_FC_PROG: reg_rdata <= fc_prog_reg;
				`VDS_OFS_STATUS: reg_rdata <= {field_sel, wr_free, last_ok_reg, line_num};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Position reference
	assign horiz_trigger_offset = {off_hi_reg[`VDS_HI_HORIZ_OFFSET_LOW], horiz_offset_low_lo_reg};
	assign vert_trigger_offset = {off_hi_reg[`VDS_HI_VERT_OFFSET_LOW], vert_offset_low_lo_reg};
	assign field_sel = field_reg ^ off_hi_reg[`VDS_HI_FIELD_OFFSET_FLAG];
	assign lref_fall = lref_d_reg && !line_reference;
	assign vref_fall = vref_d_reg && !vertical_reference;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			lref_d_reg <= 1'b0;
			vref_d_reg <= 1'b0;
			vcnt_reg <= 9'h000;
			field_reg <= 1'b0;
			hcnt_reg <= 11'h000;
		end
		else
		begin
			lref_d_reg <= line_reference;
			vref_d_reg <= vertical_reference;
			if (vref_fall)
			begin
				vcnt_reg <= 9'h000;
				field_reg <= ~field_reg;
			end
			else if (lref_fall && vcnt_reg != 9'h1ff)
				vcnt_reg <= vcnt_reg + 9'h001;
			if (lref_fall)
				hcnt_reg <= 11'h000;
			else if (hcnt_reg != 11'h7ff)
				hcnt_reg <= hcnt_reg + 11'h001;
		end
	end

	// Line number and its standard; beyond line 24 the last entry holds
	assign vrel = vcnt_reg - vert_trigger_offset;
	assign tline = (vrel > 9'(LINES - 1)) ? 5'(LINES - 1) : 5'(vrel);
	assign line_num = (vrel > 9'd29) ? 5'h1f : 5'(vrel) + `VDS_LINE_FIRST;
	always_comb
	begin
		if (vcnt_reg < vert_trigger_offset)
			cur_code = 4'hf;
		else if (field_sel)
			cur_code = lss_reg[tline][`VDS_LSS_FIELD1];
		else
			cur_code = lss_reg[tline][`VDS_LSS_FIELD0];
	end
	assign cur_info = std_info(cur_code, fc_prog_reg, setup_reg[`VDS_SETUP_OPT_HAM]);
	assign info = std_info(std_reg, fc_prog_reg, setup_reg[`VDS_SETUP_OPT_HAM]);

	// Slice level from run-in extremes
	assign lvl_sum = {1'b0, min_reg} + {1'b0, max_reg};
	assign sbit = vid_sample > lvl_sum[8:1];
	assign sedge = sbit ^ sbit_d_reg;

	always_ff @(posedge clk_sys)
	begin
		if (srst || state_reg == S_WAIT)
		begin
			min_reg <= 8'hff;
			max_reg <= 8'h00;
			sbit_d_reg <= 1'b0;
		end
		else
		begin
			sbit_d_reg <= sbit;
			if (state_reg == S_RUNIN && vid_sample < min_reg)
				min_reg <= vid_sample;
			if (state_reg == S_RUNIN && vid_sample > max_reg)
				max_reg <= vid_sample;
		end
	end

	// Bit clock phase; run-in edges pull the sample point to mid-bit
	assign phase_sum = {1'b0, phase_reg} + {1'b0, info.inc};
	assign tick = phase_sum[24] && (state_reg != S_IDLE) && (state_reg != S_WAIT);

	always_ff @(posedge clk_sys)
	begin
		if (srst || state_reg == S_WAIT)
			phase_reg <= 24'h000000;
		else if (state_reg == S_RUNIN && sedge)
			phase_reg <= `VDS_PHASE_HALF;
		else
			phase_reg <= phase_sum[23:0];
	end

	// Framing and byte assembly, oldest bit lowest
	assign sh_nx = {sbit, sh_reg[23:1]};
	assign fc_match = (sh_nx >> (5'd24 - info.fc_len)) == info.fc_word;
	assign byte_nx = {sbit, byte_reg[7:1]};
	assign ham_fail = info.ham && (errs_reg > setup_reg[`VDS_SETUP_ERR]);

	always_ff @(posedge clk_sys)
	begin
		wr_en_reg <= 1'b0;
		wr_commit_reg <= 1'b0;
		wr_abort_reg <= 1'b0;
		if (srst)
		begin
			state_reg <= S_IDLE;
			std_reg <= 4'hf;
			line_reg <= 5'h00;
			edges_reg <= 4'h0;
			rbits_reg <= 6'h00;
			fbits_reg <= 8'h00;
			sh_reg <= 24'h000000;
			byte_reg <= 8'h00;
			bcnt_reg <= 3'h0;
			nbytes_reg <= 6'h00;
			errs_reg <= 2'h0;
			last_ok_reg <= 1'b0;
		end
		else if (lref_fall)
		begin
			if (state_reg == S_DATA && nbytes_reg != 6'h00 && !ham_fail)
			begin
				wr_commit_reg <= 1'b1;
				last_ok_reg <= 1'b1;
			end
			else if (state_reg != S_IDLE && state_reg != S_WAIT)
			begin
				wr_abort_reg <= 1'b1;
				last_ok_reg <= 1'b0;
			end
			state_reg <= S_WAIT;
		end
		else
		begin
			unique case (state_reg)
				S_IDLE: state_reg <= S_IDLE;
				S_WAIT:
				begin
					if (hcnt_reg == horiz_trigger_offset)
					begin
						std_reg <= cur_code;
						line_reg <= line_num;
						edges_reg <= 4'h0;
						rbits_reg <= 6'h00;
						fbits_reg <= 8'h00;
						sh_reg <= 24'h000000;
						bcnt_reg <= 3'h0;
						nbytes_reg <= 6'h00;
						errs_reg <= 2'h0;
						state_reg <= (cur_info.active && wr_free) ? S_RUNIN : S_IDLE;
					end
				end
				S_RUNIN:
				begin
					if (sedge)
					begin
						edges_reg <= edges_reg + 4'h1;
						if (edges_reg == `VDS_LOCK_EDGES - 4'h1)
							state_reg <= info.search ? S_FRAME : S_DATA;
					end
					else if (tick)
					begin
						rbits_reg <= rbits_reg + 6'h01;
						if (rbits_reg == `VDS_RUNIN_MAX)
						begin
							wr_abort_reg <= 1'b1;
							last_ok_reg <= 1'b0;
							state_reg <= S_IDLE;
						end
					end
				end
				S_FRAME:
				begin
					if (tick)
					begin
						sh_reg <= sh_nx;
						fbits_reg <= fbits_reg + 8'h01;
						if (fc_match)
							state_reg <= S_DATA;
						else if (info.fc_win != `VDS_W_OPEN && fbits_reg == info.fc_win)
						begin
							wr_abort_reg <= 1'b1;
							last_ok_reg <= 1'b0;
							state_reg <= S_IDLE;
						end
					end
				end
				S_DATA:
				begin
					if (tick)
					begin
						byte_reg <= byte_nx;
						bcnt_reg <= bcnt_reg + 3'h1;
						if (bcnt_reg == 3'h7)
						begin
							wr_en_reg <= 1'b1;
							nbytes_reg <= nbytes_reg + 6'h01;
							if (info.ham && nbytes_reg < `VDS_HAM_BYTES && ham_bad(byte_nx)
								&& errs_reg != 2'h3)
								errs_reg <= errs_reg + 2'h1;
							if (nbytes_reg == 6'(SECT_BYTES - 1))
								state_reg <= S_IDLE;
							if (nbytes_reg == 6'(SECT_BYTES - 1))
								wr_commit_reg <= !ham_fail;
							if (nbytes_reg == 6'(SECT_BYTES - 1))
								wr_abort_reg <= ham_fail;
							if (nbytes_reg == 6'(SECT_BYTES - 1))
								last_ok_reg <= !ham_fail;
						end
					end
				end
			endcase
		end
	end

	vds_text_buffer #(
		.SECT_BYTES(SECT_BYTES),
		.TAG_W(9)
	) u_buffer (
		.clk_sys(clk_sys),
		.srst(srst),
		.wr_en(wr_en_reg),
		.wr_data(byte_reg),
		.wr_commit(wr_commit_reg),
		.wr_abort(wr_abort_reg),
		.wr_tag({line_reg, std_reg}),
		.wr_free(wr_free),
		.rd_data(txt_data),
		.rd_valid(txt_valid),
		.rd_last(txt_last),
		.rd_tag({txt_line, txt_std}),
		.rd_ready(txt_ready)
	);

endmodule : vds_slicer

// ==== dv/vds_slicer_sva.sv ====
`timescale 1ns/10ps
module vds_slicer_sva
	import vds_pkg::*;
#(
	parameter int SECT_BYTES = 56
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Sliced text stream
	input wire logic [7:0] txt_data,
	input wire logic txt_valid,
	input wire logic txt_last,
	input wire logic [4:0] txt_line,
	input wire vds_pkg::vds_code_t txt_std,
	input wire logic txt_ready
);
	int byte_cnt;

	// Bytes accepted so far in the line being drained
	always_ff @(posedge clk_sys)
	begin
		if (srst || (txt_valid && txt_ready && txt_last))
			byte_cnt <= 0;
		else if (txt_valid && txt_ready)
			byte_cnt <= byte_cnt + 1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside answer cycle");
	unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h40 || reg_addr == 8'h58
		|| reg_addr > 8'h5d) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	setup_readback_a: assert property (reg_wr && reg_addr == 8'h40 ##1 reg_rd
		&& reg_addr == 8'h40 |=> reg_rdata == $past(reg_wdata, 2))
		else $error("setup readback wrong");
	select_readback_a: assert property (reg_wr && reg_addr inside {[8'h41:8'h57]}
		##1 reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("line select readback wrong");
	offset_readback_a: assert property (reg_wr && reg_addr inside {[8'h59:8'h5b]}
		##1 reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("offset readback wrong");
	valid_hold_a: assert property (txt_valid && !txt_ready |=> txt_valid
		&& $stable(txt_data) && $stable(txt_last) && $stable(txt_line))
		else $error("stalled byte changed");
	gapless_line_a: assert property (txt_valid && txt_ready && !txt_last |=> txt_valid
		&& $stable(txt_std) && $stable(txt_line))
		else $error("gap or tag change inside a line");
	no_blank_std_a: assert property (txt_valid |-> txt_std != 4'hf)
		else $error("bytes sent for a no-data line");
	line_range_a: assert property (txt_valid |-> txt_line >= 5'd2)
		else $error("line tag below 2");
	section_size_a: assert property (txt_valid |-> byte_cnt < SECT_BYTES)
		else $error("line longer than a section");
	last_valid_a: assert property (txt_last |-> txt_valid)
		else $error("last flag without valid");

	cover property (reg_rd ##1 reg_rdata != 8'h00);
	cover property (txt_valid && txt_ready && txt_last);
	cover property (txt_valid && !txt_ready);
endmodule : vds_slicer_sva

// ==== dv/vds_video_src.sv ====
`timescale 1ns/10ps
module vds_video_src (
	// Clock
	input wire logic clk_sys,
	// Decoder video stream
	output logic [7:0] vid_sample,
	output logic line_reference,
	output logic vertical_reference
);
	localparam int RUNIN_BITS = 12;

	initial
	begin
		vid_sample = 8'h10;
		line_reference = 1'b1;
		vertical_reference = 1'b1;
	end

	// Payload byte k carries odd parity in bit 7
	function automatic logic [7:0] pay_byte(input int k);
		return {~^k[6:0], k[6:0]};
	endfunction : pay_byte

	// One line: run-in, framing word oldest bit first, then 56 bytes LSB first
	task automatic send_line(input bit vfall, input longint rate, input logic [23:0] fc,
		input int fc_len, input int n_clk);
		int idx;
		int p;
		logic b;
		logic [7:0] pb;
		for (int c = 0; c < n_clk; c++)
		begin
			@(posedge clk_sys);
			line_reference <= (c >= 32);
			vertical_reference <= !(vfall && c >= 10 && c < 42);
			idx = (rate == 0 || c < 40) ? -1 : int'(longint'(c - 40) * rate / 50000000);
			p = idx - RUNIN_BITS - fc_len;
			pb = pay_byte(p / 8);
			if (idx < 0 || p >= 56 * 8)
				b = 1'b0;
			else if (idx < RUNIN_BITS)
				b = ~idx[0];
			else if (p < 0)
				b = fc[idx - RUNIN_BITS];
			else
				b = pb[p % 8];
			vid_sample <= b ? 8'hc0 : 8'h10;
		end
	endtask : send_line
endmodule : vds_video_src

// ==== dv/test_vds_slicer.sv ====
`timescale 1ns/10ps
`define CHK(what, exp, got) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("[FAIL] %s expected %h seen %h", what, exp, got); \
		end \
	end

module test_vds_slicer;
	import vds_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic txt_ready = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] txt_data;
	logic txt_valid;
	logic txt_last;
	logic [4:0] txt_line;
	vds_code_t txt_std;
	logic [7:0] vid_sample;
	logic line_reference;
	logic vertical_reference;
	int n_errors = 0;
	int total_checks = 0;
	logic [1:0] cyc = 2'b00;
	logic [7:0] got_q[$];
	logic [4:0] line_q[$];
	vds_code_t last_std;

	always #10 clk_sys = ~clk_sys;

	vds_slicer #(.LINES(23), .SECT_BYTES(56)) vds_slicer_i (
		.clk_sys(clk_sys), .srst(srst), .vid_sample(vid_sample),
		.line_reference(line_reference), .vertical_reference(vertical_reference),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .txt_data(txt_data), .txt_valid(txt_valid),
		.txt_last(txt_last), .txt_line(txt_line), .txt_std(txt_std), .txt_ready(txt_ready)
	);

	vds_video_src vds_video_src_i (
		.clk_sys(clk_sys), .vid_sample(vid_sample), .line_reference(line_reference),
		.vertical_reference(vertical_reference)
	);

	// Sink stalls one cycle in four
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 2'b01;
		txt_ready <= (cyc != 2'b11);
		if (txt_valid && txt_ready)
		begin
			got_q.push_back(txt_data);
			if (txt_last)
			begin
				line_q.push_back(txt_line);
				last_std <= txt_std;
			end
		end
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask : reg_write

	task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CHK("reg_rdata", exp, reg_rdata)
		@(posedge clk_sys);
	endtask : reg_check

	// One field: blank lines, then two data lines, then a drain gap
	task automatic run_field(input logic [7:0] sel, input logic [7:0] last, input int n_blank,
		input longint rate, input logic [23:0] fc, input int fl, input int n_exp);
		for (int a = 8'h41; a <= 8'h57; a++)
			reg_write(8'(a), (a == 8'h57) ? last : sel);
		reg_wr <= 1'b0;
		got_q.delete();
		line_q.delete();
		vds_video_src_i.send_line(1'b1, 0, 24'h0, 0, 100);
		repeat (n_blank) vds_video_src_i.send_line(1'b0, 0, 24'h0, 0, 200);
		repeat (2) vds_video_src_i.send_line(1'b0, rate, fc, fl, 5000);
		vds_video_src_i.send_line(1'b0, 0, 24'h0, 0, 300);
		`CHK("lines", n_exp, line_q.size())
		`CHK("bytes", n_exp * 56, got_q.size())
		foreach (got_q[i])
			`CHK("byte", vds_video_src_i.pay_byte(i % 56), got_q[i])
		if (n_exp > 0)
		begin
			`CHK("std", last[3:0], last_std)
			`CHK("line", 5'(3 + n_blank), line_q[0])
		end
	endtask : run_field

	initial
	begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		reg_check(8'h40, 8'h00);
		for (int a = 8'h41; a <= 8'h57; a++)
			reg_check(8'(a), 8'hff);
		reg_check(8'h5c, 8'h27);
		reg_check(8'h5d, 8'h42);
		for (int a = 8'h59; a <= 8'h5b; a++)
			reg_check(8'(a), 8'h00);
		reg_check(8'h58, 8'h00);
		reg_write(8'h7f, 8'h55);
		reg_check(8'h7f, 8'h00);
		reg_write(8'h40, 8'h03);
		reg_check(8'h40, 8'h03);
		reg_write(8'h57, 8'h5a);
		reg_check(8'h57, 8'h5a);
		for (int a = 8'h59; a <= 8'h5b; a++)
		begin
			reg_write(8'(a), (a == 8'h5b) ? 8'h91 : 8'ha5);
			reg_check(8'(a), (a == 8'h5b) ? 8'h91 : 8'ha5);
			reg_write(8'(a), 8'h00);
		end
		reg_write(8'h40, 8'h00);
		run_field(8'h00, 8'h00, 0, 6937500, 24'h27, 8, 2);
		run_field(8'h44, 8'h44, 0, 5727200, 24'h27, 8, 2);
		run_field(8'h33, 8'h33, 0, 5000000, 24'h1e3c1f, 24, 2);
		run_field(8'hff, 8'hff, 0, 6937500, 24'h27, 8, 0);
		run_field(8'h00, 8'h00, 0, 6937500, 24'h26, 8, 0);
		run_field(8'hff, 8'h00, 21, 6937500, 24'h27, 8, 2);
		reg_write(8'h5c, 8'h2e);
		run_field(8'hee, 8'hee, 0, 5000000, 24'h2e, 8, 2);
		wrap_up();
	end

	initial
	begin
		repeat (100000) @(posedge clk_sys);
		n_errors++;
		$display("[FAIL] run_time expected done seen hang");
		wrap_up();
	end
endmodule : test_vds_slicer

bind vds_slicer vds_slicer_sva #(.SECT_BYTES(SECT_BYTES)) vds_slicer_sva_i (
	.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txt_data(txt_data),
	.txt_valid(txt_valid), .txt_last(txt_last), .txt_line(txt_line), .txt_std(txt_std),
	.txt_ready(txt_ready)
);
